// ==== csi_pkg.sv ====
// shared constants for the chip-select interrupt acknowledge and reset configuration block
package csi_pkg;
    // ******************************
    // bus encodings
    // ******************************
    localparam logic [2:0] FC_CPU_SPACE = 3'h7;
    localparam logic [1:0] FC_LOW_CPU = 2'h3;
    localparam logic [3:0] SPACE_IACK = 4'hf;
    localparam logic [1:0] SPACE_CPU = 2'h0;
    localparam logic [2:0] IPL_ANY = 3'h0;
    localparam logic [3:0] WAIT_FAST = 4'he;
    localparam logic [3:0] WAIT_EXT = 4'hf;
    localparam logic [1:0] BYTE_OFF = 2'h0;
    localparam logic [1:0] BYTE_LOW = 2'h1;
    localparam logic [1:0] BYTE_HIGH = 2'h2;
    localparam logic [1:0] BYTE_BOTH = 2'h3;
    localparam logic [1:0] RW_READ = 2'h1;
    localparam logic [1:0] RW_WRITE = 2'h2;
    localparam logic [1:0] PIN_ALT = 2'h1;
    localparam logic [1:0] PIN_CS8 = 2'h2;
    localparam logic [1:0] PIN_CS16 = 2'h3;
    // ******************************
    // address fields
    // ******************************
    localparam int ADDR_W = 24;
    localparam int BASE_LSB = 11;
    localparam int SPACE_LSB = 16;
    localparam int LEVEL_LSB = 1;
    localparam int NUM_CS = 12;
    localparam int NUM_HI = 5;
    localparam int FAST_ACK_STATES = 2;
    // ******************************
    // timing
    // ******************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int FAST_BUS_NS = 200;
    localparam int FAST_BUS_CYC = (FAST_BUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ==== csi_match_if.sv ====
// interface carrying decoded bus cycle attributes between the match unit and top
interface csi_match_if;
    logic iack;
    logic lvl_any_hit;
    logic [2:0] level;
    logic cs_hit;
    logic av_hit;
    logic ack_gen;
    logic ack16;
    modport dec (output iack, output level, output cs_hit, output av_hit, output ack_gen,
        output ack16, output lvl_any_hit);
    modport use_side (input iack, input level, input cs_hit, input av_hit, input ack_gen,
        input ack16, input lvl_any_hit);
endinterface

// ==== csi_match.sv ====
// combinational match decode for one chip select
module csi_match
    import csi_pkg::*;
(
    input wire logic [23:0] addr_i,
    input wire logic [2:0] function_code_i,
    input wire logic rnw_i,
    input wire logic [1:0] transfer_size_i,
    input wire logic addr_strobe_i,
    input wire logic ext_irq_i,
    input wire logic [12:0] base_i,
    input wire logic small_block_i,
    input wire logic [1:0] space_i,
    input wire logic [1:0] rw_sel_i,
    input wire logic [1:0] byte_sel_i,
    input wire logic [2:0] int_priority_field_i,
    input wire logic [3:0] wait_i,
    input wire logic autovec_en_i,
    input wire logic port16_i,
    csi_match_if.dec m
);
    wire logic base_ok;
    wire logic space_ok;
    wire logic rw_ok;
    wire logic byte_ok;
    wire logic lvl_ok;
    wire logic lowbyte;
    wire logic hibyte;
    wire logic iack_cyc;
    // ******************************
    // cycle classification
    // ******************************
    assign iack_cyc = (function_code_i == FC_CPU_SPACE)
        && (addr_i[SPACE_LSB+3:SPACE_LSB] == SPACE_IACK);
    // upper base bits always compared; space-type lines only for small blocks
    assign base_ok = (addr_i[ADDR_W-1:SPACE_LSB+4] == base_i[12:9])
        && (!small_block_i || addr_i[SPACE_LSB+3:SPACE_LSB] == base_i[8:5]);
    assign space_ok = iack_cyc ? (space_i == SPACE_CPU)
        : (function_code_i[1:0] != FC_LOW_CPU && space_i != SPACE_CPU);
    assign rw_ok = rnw_i ? rw_sel_i[0] : rw_sel_i[1];
    // byte lanes from address bit 0 and size
    assign lowbyte = addr_i[0] || (transfer_size_i != 2'h1);
    assign hibyte = !addr_i[0];
    assign byte_ok = (byte_sel_i == BYTE_BOTH)
        || (byte_sel_i == BYTE_LOW && lowbyte)
        || (byte_sel_i == BYTE_HIGH && hibyte);
    // level compare, %000 matches any level
    assign lvl_ok = (int_priority_field_i == IPL_ANY)
        || (int_priority_field_i == addr_i[LEVEL_LSB+2:LEVEL_LSB]);
    assign m.iack = iack_cyc;
    assign m.level = addr_i[LEVEL_LSB+2:LEVEL_LSB];
    assign m.lvl_any_hit = lvl_ok;
    assign m.cs_hit = addr_strobe_i && base_ok && space_ok && rw_ok
        && (byte_sel_i != BYTE_OFF) && byte_ok && (!iack_cyc || (lvl_ok && ext_irq_i));
    // autovector only for external pin requests
    assign m.av_hit = m.cs_hit && iack_cyc && autovec_en_i;
    // internal ack unless external supplies it; autovector forces fast
    assign m.ack_gen = autovec_en_i || (wait_i != WAIT_EXT);
    assign m.ack16 = port16_i;
endmodule

// ==== csi_top.sv ====
// chip select with interrupt acknowledge support and reset pin configuration
// Operation
// - at address strobe, decode address, function code, direction, size, strobe; strobe_select_i is not used, selects follow address strobe only.
// - write data valid in S4; internal size acknowledge generated then.
// - any chip select may assert during external-pin interrupt acknowledge on match; the code keeps the select off there when autovec_en_i is set.
// - compare level on low address lines with priority field; assert on equality.
// - priority field zero matches every interrupt level.
// - acknowledge or autovector generated only for external interrupt pin requests.
// - autovector bit and match produce internal autovector in interrupt acknowledge.
// - autovector bit forces fast termination regardless of wait field.
// - wait code 1111 means external device supplies acknowledge.
// - acknowledge is read; vector on low byte for 16-bit, high for 8-bit.
// - pin field low bit resets to one, high bit from data pin; boot field high bit one, low bit data pin 0.
// - code 11 is 16-bit chip select, 01 alternate function.
// - data pins 0..2 choose boot width, arbitration pins, function-code pins.
// - low upper data pin makes its pin and lower group pins address lines.
// - wait code 1110 selects two-clock fast termination with internal acknowledge.
// - byte field 00 off, 01 low, 10 high, 11 either byte.
module csi_top
    import csi_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [23:0] addr_i,
    input wire logic [2:0] function_code_i,
    input wire logic rnw_i,
    input wire logic [1:0] transfer_size_i,
    input wire logic addr_strobe_i,
    input wire logic ext_irq_i,
    input wire logic [7:0] data_pins_i,
    input wire logic [12:0] base_i,
    input wire logic small_block_i,
    input wire logic [1:0] space_i,
    input wire logic [1:0] rw_sel_i,
    input wire logic [1:0] byte_sel_i,
    input wire logic strobe_select_i,
    input wire logic [2:0] int_priority_field_i,
    input wire logic [3:0] wait_i,
    input wire logic autovec_en_i,
    input wire logic [3:0] cs_index_i,
    output logic chip_select_n_o,
    output logic [1:0] size_ack_o,
    output logic autovector_req_o,
    output logic vector_low_byte_o,
    output logic [1:0] pin_assign_o [NUM_CS],
    output logic [2:0] iack_level_o
);
    typedef enum logic [1:0] {
        CSI_IDLE = 2'b00,
        CSI_WAIT = 2'b01,
        CSI_ACK = 2'b10,
        CSI_HOLD = 2'b11
    } csi_state_e;

    csi_state_e state_r;
    csi_state_e state_nxt;
    logic [7:0] dp_meta_r;
    logic [7:0] dp_sync_r;
    logic [1:0] as_sync_r;
    logic [1:0] irq_sync_r;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [1:0] pa_nxt [NUM_CS];
    logic as_ok;
    logic irq_ok;
    logic port16;
    logic fast;
    logic done;
    csi_match_if mi ();

    // ******************************
    // input synchronisers
    // ******************************
    always_ff @(posedge mclk_i) begin
        dp_meta_r <= data_pins_i;
        dp_sync_r <= dp_meta_r;
        as_sync_r <= {as_sync_r[0], addr_strobe_i};
        irq_sync_r <= {irq_sync_r[0], ext_irq_i};
    end
    assign as_ok = as_sync_r[1];
    assign irq_ok = irq_sync_r[1];

    // ******************************
    // reset pin assignment
    // ******************************
    // boot field: msb one, lsb data pin 0
    assign pa_nxt[0] = {1'b1, dp_sync_r[0]};
    genvar gi;
    generate
        for (gi = 1; gi < NUM_CS; gi++) begin : g_pa
            if (gi <= 3) begin : g_arb
                assign pa_nxt[gi] = {dp_sync_r[1], 1'b1};
            end else if (gi <= 6) begin : g_fc
                assign pa_nxt[gi] = {dp_sync_r[2], 1'b1};
            end else begin : g_hi
                // pin gi-7 of the upper group: address if any pin at or above it is low
                assign pa_nxt[gi] = {&dp_sync_r[7:gi-4], 1'b1};
            end
        end
    endgenerate
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pin_assign_o <= pa_nxt;
        end
    end

    // ******************************
    // match decode
    // ******************************
    assign port16 = (pin_assign_o[cs_index_i] == PIN_CS16);
    csi_match u_match (
        .addr_i(addr_i),
        .function_code_i(function_code_i),
        .rnw_i(rnw_i),
        .transfer_size_i(transfer_size_i),
        .addr_strobe_i(as_ok),
        .ext_irq_i(irq_ok),
        .base_i(base_i),
        .small_block_i(small_block_i),
        .space_i(space_i),
        .rw_sel_i(rw_sel_i),
        .byte_sel_i(byte_sel_i),
        .int_priority_field_i(int_priority_field_i),
        .wait_i(wait_i),
        .autovec_en_i(autovec_en_i),
        .port16_i(port16),
        .m(mi.dec)
    );

    // ******************************
    // termination sequencer
    // ******************************
    assign fast = autovec_en_i || (wait_i == WAIT_FAST);
    assign done = (cnt_r == 4'h0);
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            CSI_IDLE: begin
                if (mi.cs_hit && mi.ack_gen) begin
                    state_nxt = CSI_WAIT;
                    cnt_nxt = fast ? 4'(FAST_BUS_CYC - FAST_ACK_STATES) : wait_i;
                end
            end
            CSI_WAIT: begin
                if (!as_ok) begin
                    state_nxt = CSI_IDLE;
                end else if (done) begin
                    state_nxt = CSI_ACK;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            CSI_ACK: state_nxt = CSI_HOLD;
            CSI_HOLD: begin
                if (!as_ok) begin
                    state_nxt = CSI_IDLE;
                end
            end
            default: state_nxt = CSI_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_r <= CSI_IDLE;
            cnt_r <= 4'h0;
            chip_select_n_o <= 1'b1;
            size_ack_o <= 2'h0;
            autovector_req_o <= 1'b0;
            vector_low_byte_o <= 1'b0;
            iack_level_o <= 3'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            chip_select_n_o <= !(mi.cs_hit && (!mi.iack || !autovec_en_i)
                && pin_assign_o[cs_index_i][1]);
            // ack only when not autovectoring; width from port size
            size_ack_o <= (state_nxt == CSI_ACK && !mi.av_hit)
                ? (mi.ack16 ? 2'h3 : 2'h2) : 2'h0;
            autovector_req_o <= (state_nxt == CSI_ACK) && mi.av_hit;
            vector_low_byte_o <= mi.iack && mi.ack16;
            iack_level_o <= mi.level;
        end
    end

    AST_AV_NEEDS_IACK: assert property (@(posedge mclk_i) disable iff (rst_i)
        autovector_req_o |-> $past(mi.iack) && $past(irq_ok))
        else $error("autovector without external interrupt acknowledge");
    AST_EXT_NO_ACK: assert property (@(posedge mclk_i) disable iff (rst_i)
        (wait_i == WAIT_EXT && !autovec_en_i && state_r == CSI_IDLE)
        |=> state_r == CSI_IDLE && size_ack_o == 2'h0)
        else $error("internal acknowledge with external wait code");
    AST_FAST_TWO: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_r == CSI_IDLE && mi.cs_hit && fast && mi.ack_gen)
        ##1 as_ok [*2] |-> autovector_req_o || size_ack_o != 2'h0)
        else $error("fast termination late");
    AST_LEVEL: assert property (@(posedge mclk_i) disable iff (rst_i)
        (mi.iack && mi.cs_hit) |-> (int_priority_field_i == IPL_ANY
        || int_priority_field_i == addr_i[3:1]))
        else $error("level mismatch select");
    AST_BYTE_OFF: assert property (@(posedge mclk_i) disable iff (rst_i)
        byte_sel_i == BYTE_OFF |=> chip_select_n_o)
        else $error("select with byte field off");
    AST_PIN_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
        !$past(rst_i) |-> $stable(pin_assign_o[0]))
        else $error("pin fields changed after reset");
    AST_BOOT_MSB: assert property (@(posedge mclk_i) disable iff (rst_i)
        pin_assign_o[0][1] && pin_assign_o[1][0] && pin_assign_o[11][0])
        else $error("pin field fixed bit wrong");
    AST_ACK_ONE: assert property (@(posedge mclk_i) disable iff (rst_i)
        size_ack_o != 2'h0 |=> size_ack_o == 2'h0)
        else $error("acknowledge longer than one cycle");
endmodule

// ==== csi_bus_model.sv ====
// bus master model issuing interrupt acknowledge read cycles
module csi_bus_model
    import csi_pkg::*;
(
    input wire logic mclk_i,
    input wire logic done_i,
    input wire logic chip_select_n_i,
    output logic [23:0] addr_o,
    output logic [2:0] function_code_o,
    output logic rnw_o,
    output logic [1:0] transfer_size_o,
    output logic addr_strobe_o,
    output logic ext_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs_seen;
    initial begin
        addr_o = 24'h0;
        function_code_o = 3'h0;
        rnw_o = 1'h0;
        transfer_size_o = 2'h0;
        addr_strobe_o = 1'h0;
        ext_irq_o = 1'h0;
        cs_seen = 1'h0;
    end
    // ******************************
    // one cycle, strobe held until an answer or the limit
    // ******************************
    task automatic run(input logic [2:0] lvl, input logic ext, input int limit);
        int n;
        @(posedge mclk_i);
        addr_o <= {4'hf, SPACE_IACK, 12'hfff, lvl, 1'h1};
        function_code_o <= FC_CPU_SPACE;
        rnw_o <= 1'h1;
        transfer_size_o <= 2'h1;
        ext_irq_o <= ext;
        cs_seen <= 1'h0;
        @(posedge mclk_i);
        addr_strobe_o <= 1'h1;
        for (n = 0; n < limit; n++) begin
            @(posedge mclk_i);
            if (chip_select_n_i === 1'h0) cs_seen <= 1'h1;
            if (done_i === 1'h1) break;
        end
        addr_strobe_o <= 1'h0;
        repeat (2) @(posedge mclk_i);
        addr_o <= ~addr_o;
        function_code_o <= ~function_code_o;
        transfer_size_o <= ~transfer_size_o;
    endtask
endmodule

// ==== csi_top_test.sv ====
// self-checking bench for the chip-select acknowledge and reset configuration block
module csi_top_test
    import csi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'h0, rst_i = 1'h1, small_block_i = 1'h1, autovec_en_i = 1'h0, ext_irq_i;
    logic rnw_i, addr_strobe_i, done, chip_select_n_o, autovector_req_o, vector_low_byte_o;
    logic [23:0] addr_i;
    logic [2:0] function_code_i, int_priority_field_i = 3'h0, iack_level_o, lv, ipf;
    logic [1:0] transfer_size_i, space_i = SPACE_CPU, rw_sel_i = RW_READ, byte_sel_i = 2'h0;
    logic [7:0] data_pins_i = 8'hff, d;
    logic [12:0] base_i = 13'h1fff;
    logic [3:0] wait_i = WAIT_FAST, wt, cn, cs_index_i = 4'h0;
    logic [1:0] size_ack_o, bs, rw, pf;
    logic [1:0] pin_assign_o [NUM_CS];
    logic [7:0] notes [$];
    logic [7:0] nt;
    logic ext, av, hit;
    logic [31:0] seed = 32'd17;
    int fails = 0, comparisons = 0, r, k, i;
    always #50 mclk_i = ~mclk_i;
    assign done = (size_ack_o != 2'h0) || autovector_req_o;
    csi_bus_model bm (.mclk_i(mclk_i), .done_i(done), .chip_select_n_i(chip_select_n_o),
        .addr_o(addr_i), .function_code_o(function_code_i), .rnw_o(rnw_i),
        .transfer_size_o(transfer_size_i), .addr_strobe_o(addr_strobe_i), .ext_irq_o(ext_irq_i));
    csi_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
        .function_code_i(function_code_i), .rnw_i(rnw_i), .transfer_size_i(transfer_size_i),
        .addr_strobe_i(addr_strobe_i), .ext_irq_i(ext_irq_i), .data_pins_i(data_pins_i),
        .base_i(base_i), .small_block_i(small_block_i), .space_i(space_i), .rw_sel_i(rw_sel_i),
        .byte_sel_i(byte_sel_i), .strobe_select_i(1'h0),
        .int_priority_field_i(int_priority_field_i),
        .wait_i(wait_i), .autovec_en_i(autovec_en_i), .cs_index_i(cs_index_i),
        .chip_select_n_o(chip_select_n_o), .size_ack_o(size_ack_o),
        .autovector_req_o(autovector_req_o), .vector_low_byte_o(vector_low_byte_o),
        .pin_assign_o(pin_assign_o), .iack_level_o(iack_level_o));
    // ******************************
    // helpers
    // ******************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] exp_field(input logic [7:0] p, input int n);
        if (n == 0) return {1'h1, p[0]};
        if (n < 4) return {p[1], 1'h1};
        if (n < 7) return {p[2], 1'h1};
        return {(p | (8'hff >> (12 - n))) == 8'hff, 1'h1};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ******************************
    // answer monitor
    // ******************************
    always @(posedge mclk_i) begin
        if (rst_i === 1'h0 && (size_ack_o !== 2'h0 || autovector_req_o !== 1'h0)) begin
            if (notes.size() > 0) nt = notes.pop_front();
            else nt = 8'h08;
            if (nt[3]) check("size ack", 8'(size_ack_o), 8'(nt[2:1]));
            check("autovector", 8'(autovector_req_o), 8'(nt[0]));
            check("vector low byte", 8'(vector_low_byte_o), 8'(nt[4]));
            check("iack level", 8'(iack_level_o), 8'(nt[7:5]));
        end
    end
    initial begin
        repeat (30000) @(posedge mclk_i);
        fails++;
        print_verdict();
    end
    // ******************************
    // main sequence
    // ******************************
    initial begin
        for (r = 0; r < 4; r++) begin
            @(posedge mclk_i);
            d = 8'(rnd());
            rst_i <= 1'h1;
            data_pins_i <= d;
            repeat (4) @(posedge mclk_i);
            rst_i <= 1'h0;
            data_pins_i <= ~d;
            repeat (4) @(posedge mclk_i);
            for (i = 0; i < NUM_CS; i++) begin
                check("pin field", 8'(pin_assign_o[i]),
                    8'(exp_field(d, i)));
            end
            for (k = 0; k < 9; k++) begin
                lv = 3'(rnd() % 7 + 1);
                ipf = lv;
                ext = 1'h1;
                av = 1'h0;
                wt = WAIT_FAST;
                bs = BYTE_BOTH;
                rw = RW_READ;
                hit = (k < 2) || (k == 4) || (k == 8);
                case (k)
                    1: ipf = IPL_ANY;
                    2: ipf = (lv == 3'h7) ? 3'h1 : lv + 3'h1;
                    3: ext = 1'h0;
                    4: av = 1'h1;
                    5: wt = WAIT_EXT;
                    6: bs = BYTE_OFF;
                    7: rw = RW_WRITE;
                    8: wt = 4'(rnd() % 8);
                    default: ;
                endcase
                if (k == 4) wt = 4'(rnd());
                cn = 4'(rnd() % NUM_CS);
                pf = exp_field(d, int'(cn));
                @(posedge mclk_i);
                cs_index_i <= cn;
                int_priority_field_i <= ipf;
                autovec_en_i <= av;
                wait_i <= wt;
                byte_sel_i <= bs;
                rw_sel_i <= rw;
                if (hit) notes.push_back({lv, (pf == PIN_CS16), ~av,
                    ((pf == PIN_CS16) ? 2'h3 : 2'h2), av});
                bm.run(lv, ext, hit ? 24 : 8);
                repeat (3) @(posedge mclk_i);
                if (k != 3 && k != 4) check("chip select", 8'(bm.cs_seen),
                    8'((k < 2 || k > 4 && k != 6 && k != 7) && pf[1]));
                check("pending answers", 8'(notes.size()), 8'h0);
            end
        end
        print_verdict();
    end
endmodule
